// *** core/dps_pushout_seq.sv ***
// Pushout sequencer for a dual purge applicator, with APB register slave
//
// Local design decisions: register access over APB and the placing of the registers.
`include "dps_consts.svh"

module dps_pushout_seq
    import dps_pkg::*;
(
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  pushout_pin,
    input  wire logic                  a_fill_pin,
    input  wire logic                  resin_fb_pin,
    output logic                       run_out,
    output logic      [`DPS_RATE_W:0]  ch1_rate,
    output logic      [`DPS_RATE_W-1:0] ch2_rate,
    output logic                       side_b_motor_en,
    output logic                       gun2_run_out
);
    logic                   push_s;
    logic                   afill_s;
    logic                   fb_s;
    logic                   fb_d_reg;
    logic                   fb_rise;
    dps_state_t             state_reg;
    dps_state_t             state_next;
    logic [`DPS_RATE_W-1:0] resin_reg;
    logic [`DPS_RATE_W-1:0] cat_reg;
    logic [`DPS_VOL_W-1:0]  mixvol_reg;
    logic [`DPS_VOL_W-1:0]  count_reg;
    logic [`DPS_RATE_W:0]   total_reg;
    logic                   gun2_en_reg;
    logic                   acc_wr;
    logic                   start_wr;
    logic                   stop_wr;
    logic                   vol_done;
    logic                   hit;
    logic [31:0]            rd_word;

    dps_sync u_sync_push (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (pushout_pin),
        .q       (push_s)
    );

    dps_sync u_sync_afill (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (a_fill_pin),
        .q       (afill_s)
    );

    dps_sync u_sync_fb (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (resin_fb_pin),
        .q       (fb_s)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fb_d_reg <= 1'b0;
        end else begin
            fb_d_reg <= fb_s;
        end
    end

    assign fb_rise  = fb_s & ~fb_d_reg;
    assign acc_wr   = psel & penable & pready & pwrite;
    assign start_wr = acc_wr && (paddr == `DPS_OFF_CTRL) && pwdata[`DPS_CTRL_START];
    assign stop_wr  = acc_wr && (paddr == `DPS_OFF_CTRL) && pwdata[`DPS_CTRL_STOP];
    assign vol_done = (count_reg >= mixvol_reg);

    // APB slave: one wait cycle so read data comes from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= psel & penable & ~pready;
        end
    end

    always_comb begin
        hit     = 1'b1;
        rd_word = `DPS_RST_WORD;
        unique case (paddr)
            `DPS_OFF_CTRL:   rd_word[`DPS_CTRL_GUN2] = gun2_en_reg;
            `DPS_OFF_RESIN:  rd_word[`DPS_RATE_W-1:0] = resin_reg;
            `DPS_OFF_CAT:    rd_word[`DPS_RATE_W-1:0] = cat_reg;
            `DPS_OFF_MIXVOL: rd_word[`DPS_VOL_W-1:0] = mixvol_reg;
            `DPS_OFF_STATUS: rd_word[4:0] = {run_out, afill_s, push_s, state_reg};
            `DPS_OFF_COUNT:  rd_word[`DPS_VOL_W-1:0] = count_reg;
            default:         hit = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= `DPS_RST_WORD;
            pslverr <= 1'b0;
        end else if (psel && penable && !pready) begin
            prdata  <= pwrite ? `DPS_RST_WORD : rd_word;
            pslverr <= ~hit;
        end else begin
            pslverr <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            resin_reg   <= `DPS_RST_RATE;
            cat_reg     <= `DPS_RST_RATE;
            mixvol_reg  <= `DPS_RST_VOL;
            gun2_en_reg <= 1'b0;
        end else if (acc_wr) begin
            unique case (paddr)
                `DPS_OFF_CTRL:   gun2_en_reg <= pwdata[`DPS_CTRL_GUN2];
                `DPS_OFF_RESIN:  resin_reg   <= pwdata[`DPS_RATE_W-1:0];
                `DPS_OFF_CAT:    cat_reg     <= pwdata[`DPS_RATE_W-1:0];
                `DPS_OFF_MIXVOL: mixvol_reg  <= pwdata[`DPS_VOL_W-1:0];
                default:         ;
            endcase
        end
    end

    // Sequencer for gun 1
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            DPS_ST_IDLE: begin
                if (start_wr) begin
                    state_next = DPS_ST_RUN;
                end
            end
            DPS_ST_RUN: begin
                if (stop_wr) begin
                    state_next = DPS_ST_IDLE;
                end else if (push_s) begin
                    state_next = DPS_ST_PUSH;
                end
            end
            DPS_ST_PUSH: begin
                if (stop_wr) begin
                    state_next = DPS_ST_IDLE;
                end else if (!push_s) begin
                    // Level dropped early: pushout cancelled, back to mixing
                    state_next = DPS_ST_RUN;
                end else if (vol_done) begin
                    state_next = DPS_ST_HALT;
                end
            end
            DPS_ST_HALT: begin
                // Wait for the controller to release pushout before rearming
                if (!push_s) begin
                    state_next = DPS_ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= DPS_ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Total latched at pushout entry, so later rate writes do not disturb it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            total_reg <= {1'b0, `DPS_RST_RATE};
        end else if (state_reg != DPS_ST_PUSH && state_next == DPS_ST_PUSH) begin
            total_reg <= {1'b0, resin_reg} + {1'b0, cat_reg};
        end
    end

    // Pushout volume in resin feedback pulses, saturating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= `DPS_RST_VOL;
        end else if (state_reg != DPS_ST_PUSH && state_next == DPS_ST_PUSH) begin
            count_reg <= `DPS_RST_VOL;
        end else if (state_reg == DPS_ST_PUSH && fb_rise && count_reg != `DPS_VOL_MAX) begin
            count_reg <= count_reg + `DPS_VOL_ONE;
        end
    end

    // Pump commands follow the next state so they change with it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ch1_rate <= {1'b0, `DPS_RST_RATE};
            ch2_rate <= `DPS_RST_RATE;
            run_out  <= 1'b0;
        end else begin
            unique case (state_next)
                DPS_ST_RUN: begin
                    ch1_rate <= {1'b0, resin_reg};
                    ch2_rate <= cat_reg;
                end
                DPS_ST_PUSH: begin
                    ch1_rate <= (state_reg == DPS_ST_PUSH) ? total_reg
                              : ({1'b0, resin_reg} + {1'b0, cat_reg});
                    ch2_rate <= `DPS_RST_RATE;
                end
                default: begin
                    ch1_rate <= {1'b0, `DPS_RST_RATE};
                    ch2_rate <= `DPS_RST_RATE;
                end
            endcase
            run_out <= (state_next == DPS_ST_RUN) || (state_next == DPS_ST_PUSH);
        end
    end

    // Side B drive held off during pushout to stop resin backflow
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            side_b_motor_en <= 1'b0;
            gun2_run_out    <= 1'b0;
        end else begin
            side_b_motor_en <= afill_s & ~push_s;
            gun2_run_out    <= gun2_en_reg;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_cat_stop: assert property (
        (state_reg == DPS_ST_RUN && push_s && !stop_wr)
        |=> (ch2_rate == `DPS_RST_RATE && state_reg == DPS_ST_PUSH && run_out))
        else $error("Catalyst not stopped on pushout");

    chk_total_kept: assert property (
        (state_reg == DPS_ST_RUN && state_next == DPS_ST_PUSH)
        |=> (ch1_rate == {1'b0, $past(resin_reg)} + {1'b0, $past(cat_reg)})
            ##1 (state_reg != DPS_ST_PUSH || ch1_rate == total_reg))
        else $error("Resin rate does not hold prior total");

    chk_level_held: assert property (
        (state_reg == DPS_ST_PUSH && !push_s && !stop_wr) |=> state_reg == DPS_ST_RUN)
        else $error("Pushout release not honoured");

    chk_volume_halt: assert property (
        (state_reg == DPS_ST_PUSH && push_s && !stop_wr && vol_done)
        |=> (state_reg == DPS_ST_HALT && !run_out && ch1_rate == {1'b0, `DPS_RST_RATE}))
        else $error("Gun not halted at mixed volume");

    chk_run_drop: assert property (
        $fell(run_out) |-> (state_reg == DPS_ST_HALT || state_reg == DPS_ST_IDLE))
        else $error("Run output fell outside a halt");

    chk_side_b: assert property (
        (afill_s && !push_s) |=> side_b_motor_en)
        else $error("Side B drive not enabled by fill");

    chk_side_b_off: assert property (
        push_s |=> !side_b_motor_en)
        else $error("Side B drive on during pushout");

    chk_gun2_free: assert property (
        (state_reg == DPS_ST_PUSH && gun2_en_reg) |=> gun2_run_out)
        else $error("Gun 2 blocked during pushout");

    chk_pulse_count: assert property (
        (state_reg == DPS_ST_PUSH && state_next == DPS_ST_PUSH && fb_rise
         && count_reg != `DPS_VOL_MAX)
        |=> count_reg == $past(count_reg) + `DPS_VOL_ONE)
        else $error("Feedback pulse not counted");

    chk_count_clear: assert property (
        (state_reg == DPS_ST_RUN && state_next == DPS_ST_PUSH) |=> count_reg == `DPS_RST_VOL)
        else $error("Pushout count not cleared");

    chk_apb_ready: assert property (
        (psel && penable && !pready) |=> pready ##1 !pready)
        else $error("APB answer not one wait cycle");

    chk_halt_hold: assert property (
        (state_reg == DPS_ST_HALT && push_s) |=> (state_reg == DPS_ST_HALT && !run_out))
        else $error("Halted gun restarted while pushout held");

    chk_stop_abort: assert property (
        (stop_wr && (state_reg == DPS_ST_RUN || state_reg == DPS_ST_PUSH))
        |=> (state_reg == DPS_ST_IDLE && !run_out))
        else $error("Stop did not take the gun out of run");

    chk_idle_push: assert property (
        (state_reg == DPS_ST_IDLE && !start_wr) |=> (state_reg == DPS_ST_IDLE && !run_out))
        else $error("Idle gun left idle without start");
endmodule

// *** core/dps_consts.svh ***
// Register offsets, field positions and reset values of the pushout sequencer
`ifndef DPS_CONSTS_SVH
`define DPS_CONSTS_SVH

`define DPS_OFF_CTRL      8'h00
`define DPS_OFF_RESIN     8'h04
`define DPS_OFF_CAT       8'h08
`define DPS_OFF_MIXVOL    8'h0C
`define DPS_OFF_STATUS    8'h10
`define DPS_OFF_COUNT     8'h14

`define DPS_CTRL_START    0
`define DPS_CTRL_STOP     1
`define DPS_CTRL_GUN2     2

`define DPS_RATE_W        16
`define DPS_VOL_W         24

`define DPS_RST_RATE      16'h0000
`define DPS_RST_VOL       24'h00_0000
`define DPS_RST_WORD      32'h0000_0000
`define DPS_VOL_ONE       24'h00_0001
`define DPS_VOL_MAX       24'hFF_FFFF

`endif

// *** core/dps_pkg.sv ***
// Types shared by the pushout sequencer
package dps_pkg;

    typedef enum logic [1:0] {
        DPS_ST_IDLE = 2'b00,
        DPS_ST_RUN  = 2'b01,
        DPS_ST_PUSH = 2'b10,
        DPS_ST_HALT = 2'b11
    } dps_state_t;

endpackage

// *** core/dps_sync.sv ***
// Two-flop synchroniser for one pin level
module dps_sync (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic d,
    output logic      q
);
    logic meta_reg;

    // First flop feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= 1'b0;
            q        <= 1'b0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule

// *** testbench/dps_cell_model.sv ***
// Cell controller model: pushout handshake, relay bank, resin feedback
module dps_cell_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic run_out,
    input  wire logic go,
    input  wire logic fill_only,
    input  wire logic fb_en,
    input  wire logic abort,
    output logic      pushout_pin,
    output logic      a_fill_pin,
    output logic      resin_fb_pin,
    output logic      solvent_on,
    output logic      relay_on
);
    timeunit 1ns;
    timeprecision 1ps;

    logic       run_seen;
    logic [1:0] fb_cnt;

    // Fill always rides with pushout, so only the pushout level holds side B drive off
    assign a_fill_pin = pushout_pin | fill_only;
    // Pulses two cycles high, two low, so each edge survives the synchroniser
    assign resin_fb_pin = fb_cnt[1];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pushout_pin <= 1'b0;
            solvent_on <= 1'b0;
            run_seen <= 1'b0;
            relay_on <= 1'b0;
        end else if (!pushout_pin) begin
            pushout_pin <= go; // Held as a level until run drops
            solvent_on <= go; // Solvent swapped in with pushout
            run_seen <= 1'b0;
        end else if (abort) begin
            pushout_pin <= 1'b0; // Withdrawn early, relays untouched
        end else begin
            run_seen <= run_seen | run_out;
            if (run_seen && !run_out) begin
                pushout_pin <= 1'b0; // Falling run marks the end
                relay_on <= !relay_on; // Energise, then restore channel 2
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fb_cnt <= 2'b00;
        end else begin
            fb_cnt <= fb_en ? fb_cnt + 2'b01 : 2'b00;
        end
    end
endmodule

// *** testbench/dps_pushout_seq_tb.sv ***
// Self-checking bench for the pushout sequencer
`include "dps_consts.svh"

module dps_pushout_seq_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, go, fill_only, fb_en, e, abort;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic        pready, pslverr, pushout_pin, a_fill_pin, resin_fb_pin;
    logic        run_out, side_b_motor_en, gun2_run_out, relay_on;
    logic [16:0] ch1_rate;
    logic [15:0] ch2_rate, resin, cat;
    logic [23:0] vol;
    int          mismatches = 0;
    int          checks_done = 0;
    int          n;

    always #10 pclk = ~pclk;

    dps_pushout_seq dps_pushout_seq_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pushout_pin(pushout_pin),
        .a_fill_pin(a_fill_pin), .resin_fb_pin(resin_fb_pin), .run_out(run_out),
        .ch1_rate(ch1_rate), .ch2_rate(ch2_rate), .side_b_motor_en(side_b_motor_en),
        .gun2_run_out(gun2_run_out)
    );

    dps_cell_model dps_cell_model_inst (
        .pclk(pclk), .presetn(presetn), .run_out(run_out), .go(go),
        .fill_only(fill_only), .fb_en(fb_en), .abort(abort), .pushout_pin(pushout_pin),
        .a_fill_pin(a_fill_pin), .resin_fb_pin(resin_fb_pin), .solvent_on(),
        .relay_on(relay_on)
    );

    task automatic stop_test();
        if (mismatches == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One APB transfer; holds the request until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, exp, q);
    endtask

    initial begin
        repeat (5000) @(posedge pclk);
        mismatches++;
        stop_test();
    end

    initial begin
        {presetn, psel, penable, pwrite, go, fill_only, fb_en, abort} = 8'h00;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        n = $urandom(46);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 6; i++) begin
            rd(8'(4 * i), `DPS_RST_WORD, "reset value");
        end
        apb(1'b1, 8'h18, 32'h0000_0001);
        chk("unmapped error", 32'h0000_0001, 32'(e));
        apb(1'b1, `DPS_OFF_STATUS, 32'hFFFF_FFFF);
        rd(`DPS_OFF_STATUS, `DPS_RST_WORD, "status read only");
        // First pass uses zero volume: halts right after entering pushout
        for (int k = 0; k < 2; k++) begin
            resin = 16'($urandom);
            cat = 16'($urandom_range(16'hFFFF, 1));
            vol = (k == 0) ? `DPS_RST_VOL : 24'($urandom_range(6, 1));
            apb(1'b1, `DPS_OFF_RESIN, 32'(resin));
            apb(1'b1, `DPS_OFF_CAT, 32'(cat));
            apb(1'b1, `DPS_OFF_MIXVOL, 32'(vol));
            apb(1'b1, `DPS_OFF_CTRL, (32'(k) << `DPS_CTRL_GUN2) | 32'h0000_0001);
            @(posedge pclk);
            chk("ch1 run", 32'(resin), 32'(ch1_rate));
            chk("ch2 run", 32'(cat), 32'(ch2_rate));
            rd(`DPS_OFF_STATUS, 32'h0000_0011, "status run");
            go <= 1'b1;
            @(posedge pclk);
            go <= 1'b0;
            n = 0;
            do begin
                @(posedge pclk);
                n++;
            end while (ch2_rate !== 16'h0000 && n < 20);
            chk("ch1 pushout", 32'(resin) + 32'(cat), 32'(ch1_rate));
            chk("gun2 run", 32'(k), 32'(gun2_run_out));
            chk("side b pushout", 32'h0000_0000, 32'(side_b_motor_en));
            fb_en <= 1'b1;
            n = 0;
            do begin
                @(posedge pclk);
                n++;
            end while (run_out !== 1'b0 && n < 200);
            fb_en <= 1'b0;
            chk("run dropped", 32'h0000_0000, 32'(run_out));
            chk("ch1 halted", 32'h0000_0000, 32'(ch1_rate));
            repeat (4) @(posedge pclk);
            chk("relay", 32'(k == 0), 32'(relay_on));
            rd(`DPS_OFF_COUNT, 32'(vol), "pushout count");
            rd(`DPS_OFF_STATUS, 32'h0000_0000, "status idle");
        end
        // Pushout withdrawn early returns to mixing; STOP then ends the run
        apb(1'b1, `DPS_OFF_CTRL, 32'h0000_0001);
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (ch2_rate !== 16'h0000 && n < 20);
        chk("ch2 pushout", 32'h0000_0000, 32'(ch2_rate));
        abort <= 1'b1;
        @(posedge pclk);
        abort <= 1'b0;
        repeat (5) @(posedge pclk);
        chk("ch1 cancel", 32'(resin), 32'(ch1_rate));
        chk("ch2 cancel", 32'(cat), 32'(ch2_rate));
        rd(`DPS_OFF_STATUS, 32'h0000_0011, "status cancel");
        apb(1'b1, `DPS_OFF_CTRL, 32'h0000_0002);
        @(posedge pclk);
        chk("run stopped", 32'h0000_0000, 32'(run_out));
        chk("ch1 stopped", 32'h0000_0000, 32'(ch1_rate));
        // Pushout while idle is ignored
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        repeat (4) @(posedge pclk);
        rd(`DPS_OFF_STATUS, 32'h0000_000C, "pushout ignored idle");
        abort <= 1'b1;
        @(posedge pclk);
        abort <= 1'b0;
        fill_only <= 1'b1;
        repeat (5) @(posedge pclk);
        chk("side b fill", 32'h0000_0001, 32'(side_b_motor_en));
        stop_test();
    end
endmodule
